/* File: rdw_ahb_regs.v */
// AHB-Lite register slave of the receive descriptor writeback engine
`timescale 1ns/10ps
`include "rdw_consts.vh"

module rdw_ahb_regs (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // control to the engine
  output reg  [31:0] head_ptr,
  output reg         start_pulse,
  output reg         td_pulse,
  output reg  [3:0]  pass_en,
  output reg  [15:0] rx_write_offset_setting,
  // state from the engine
  input  wire        st_active,
  input  wire        st_halted,
  input  wire        st_td_done,
  input  wire [31:0] st_cur,
  input  wire [31:0] st_frames
);

  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;
  wire       addr_phase;

  assign addr_phase = hsel & hready & htrans[`RDW_HTRANS_ACT];

  function [31:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        `RDW_REG_CTRL:   read_mux = {24'h000000, pass_en, 4'h0};
        `RDW_REG_HEAD:   read_mux = head_ptr;
        `RDW_REG_OFFSET: read_mux = {16'h0000, rx_write_offset_setting};
        `RDW_REG_STATUS: read_mux = {29'h0000_0000, st_td_done, st_halted, st_active};
        `RDW_REG_CUR:    read_mux = st_cur;
        `RDW_REG_FRAMES: read_mux = st_frames;
        default:         read_mux = `RDW_ZERO32;
      endcase
    end
  endfunction

  // zero wait states: read data is prepared at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata                  <= `RDW_ZERO32;
      hreadyout               <= 1'b1;
      hresp                   <= 1'b0;
      wr_pend_reg             <= 1'b0;
      wr_addr_reg             <= 8'h00;
      head_ptr                <= `RDW_ZERO32;
      start_pulse             <= 1'b0;
      td_pulse                <= 1'b0;
      pass_en                 <= 4'h0;
      rx_write_offset_setting <= `RDW_ZERO16;
    end else begin
      start_pulse <= 1'b0;
      td_pulse    <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
        hrdata      <= hwrite ? `RDW_ZERO32 : read_mux(haddr[7:0]);
      end
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `RDW_REG_CTRL: begin
            pass_en  <= hwdata[`RDW_CTRL_CTLF:`RDW_CTRL_ERR];
            td_pulse <= hwdata[`RDW_CTRL_TD];
          end
          `RDW_REG_HEAD: begin
            head_ptr    <= {hwdata[31:2], 2'b00};
            start_pulse <= (hwdata[31:2] != 30'h0000_0000);
          end
          `RDW_REG_OFFSET: rx_write_offset_setting <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

endmodule // rdw_ahb_regs

/* File: rdw_consts.vh */
// constants of the receive descriptor writeback engine
`ifndef RDW_CONSTS_VH
`define RDW_CONSTS_VH

// byte offsets of the four descriptor words
`define RDW_DESC_NEXT   32'h0000_0000
`define RDW_DESC_BUF    32'h0000_0004
`define RDW_DESC_LEN    32'h0000_0008
`define RDW_DESC_FLAGS  32'h0000_000C

// flag bit positions inside the fourth descriptor word
`define RDW_F_SOP       31
`define RDW_F_EOP       30
`define RDW_F_DEVICE_HELD_FLAG     29
`define RDW_F_EOQ       28
`define RDW_F_TDDONE    27
`define RDW_F_CRCKEPT   26
`define RDW_F_JABBER    25
`define RDW_F_OVERSIZE  24
`define RDW_F_FRAGMENT  23
`define RDW_F_UNDERSIZE 22
`define RDW_F_CONTROL   21
`define RDW_F_OVERRUN   20
`define RDW_F_SYMBOL    19
`define RDW_F_ALIGN     18
`define RDW_F_CHECKSUM  17
`define RDW_F_MISS      16

// register byte addresses
`define RDW_REG_CTRL    8'h00
`define RDW_REG_HEAD    8'h04
`define RDW_REG_OFFSET  8'h08
`define RDW_REG_STATUS  8'h0C
`define RDW_REG_CUR     8'h10
`define RDW_REG_FRAMES  8'h14

// control register fields
`define RDW_CTRL_TD     0
`define RDW_CTRL_ERR    4
`define RDW_CTRL_SHORT  5
`define RDW_CTRL_ALL    6
`define RDW_CTRL_CTLF   7

// status register fields
`define RDW_ST_ACTIVE   0
`define RDW_ST_HALTED   1
`define RDW_ST_TDDONE   2

// misc
`define RDW_ZERO32      32'h0000_0000
`define RDW_ZERO16      16'h0000
`define RDW_HTRANS_ACT  1

`endif

/* File: rdw_mem_model.sv */
// behavioural host memory holding descriptors and buffers
`timescale 1ns/10ps
module rdw_mem_model (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // memory slave
  input  wire        mem_req,
  input  wire        mem_write,
  input  wire        mem_byte,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata,
  // wait cycles before each ack
  input  wire [3:0]  lat
);
  reg [31:0] m [0:255];
  reg [3:0]  cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt     <= 4'h0;
      if (!mem_write) mem_rdata <= m[mem_addr[9:2]];
      else if (mem_byte) m[mem_addr[9:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[7:0];
      else m[mem_addr[9:2]] <= mem_wdata;
    end else begin
      mem_ack   <= 1'b0;
      cnt       <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      // stale read data is scrambled so a late sample cannot pass
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // rdw_mem_model

/* File: rdw_top.v */
// receive descriptor walker and writeback engine with its register slave
`timescale 1ns/10ps
`include "rdw_consts.vh"

module rdw_top #(
  parameter LEN_W = 16
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite register slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // host memory master
  output reg         mem_req,
  output reg         mem_write,
  output reg         mem_byte,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // received byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_last,
  output reg         rx_ready,
  // frame status, sampled with the last byte
  input  wire        rx_crc_kept,
  input  wire        rx_jabber,
  input  wire        rx_oversize,
  input  wire        rx_fragment,
  input  wire        rx_undersize,
  input  wire        rx_control_frame,
  input  wire        rx_overrun,
  input  wire        rx_symbol_fault,
  input  wire        rx_alignment_fault,
  input  wire        rx_checksum_fault,
  input  wire        rx_address_miss
);

  localparam S_IDLE   = 4'h0;
  localparam S_RDNEXT = 4'h1;
  localparam S_RDBUF  = 4'h2;
  localparam S_RDLEN  = 4'h3;
  localparam S_WAIT   = 4'h4;
  localparam S_DATA   = 4'h5;
  localparam S_BYTE   = 4'h6;
  localparam S_DROP   = 4'h7;
  localparam S_WBLEN  = 4'h8;
  localparam S_WBEOP  = 4'h9;
  localparam S_WBSOP  = 4'hA;
  localparam S_TD     = 4'hB;
  localparam S_HALT   = 4'hC;

  wire [31:0] head_ptr;
  wire        start_pulse;
  wire        td_pulse;
  wire [3:0]  pass_en;
  wire [15:0] rx_write_offset_setting;

  reg  [3:0]       state_reg;
  reg  [31:0]      cur_reg;
  reg  [31:0]      next_reg;
  reg  [31:0]      buf_reg;
  reg  [LEN_W-1:0] buf_len_reg;
  reg  [31:0]      sop_desc_reg;
  reg              is_sop_reg;
  reg              in_frame_reg;
  reg              frame_end_reg;
  reg  [LEN_W-1:0] buf_cnt_reg;
  reg  [LEN_W-1:0] frame_cnt_reg;
  reg  [15:0]      write_offset_value_reg;
  reg              last_reg;
  reg              trunc_reg;
  reg              eoq_reg;
  reg  [10:0]      stat_reg;
  reg              td_pend_reg;
  reg              td_done_reg;
  reg              halted_reg;
  reg  [31:0]      frames_reg;

  wire [LEN_W-1:0] wr_off;
  wire [LEN_W-1:0] cap;
  wire             buf_full;
  wire [31:0]      byte_addr;
  wire             rx_take;
  wire [15:0]      flag_hi;
  wire [31:0]      sop_word;
  wire [31:0]      eop_word;
  wire             single_buf;

  rdw_ahb_regs u_regs (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hready),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .head_ptr                (head_ptr),
    .start_pulse             (start_pulse),
    .td_pulse                (td_pulse),
    .pass_en                 (pass_en),
    .rx_write_offset_setting (rx_write_offset_setting),
    .st_active               (in_frame_reg),
    .st_halted               (halted_reg),
    .st_td_done              (td_done_reg),
    .st_cur                  (cur_reg),
    .st_frames               (frames_reg)
  );

  // offset counts only in the frame start buffer
  assign wr_off    = is_sop_reg ? rx_write_offset_setting[LEN_W-1:0] : {LEN_W{1'b0}};
  assign cap       = buf_len_reg - wr_off;
  assign buf_full  = (buf_cnt_reg == cap);
  assign byte_addr = buf_reg + {{(32-LEN_W){1'b0}}, wr_off}
                     + {{(32-LEN_W){1'b0}}, buf_cnt_reg};
  assign rx_take   = rx_valid & rx_ready;
  assign single_buf = (sop_desc_reg == cur_reg);

  // status flags as captured with the last byte, gated by the pass enables except crc kept and overrun
  assign flag_hi[15]  = 1'b1;
  assign flag_hi[14]  = single_buf;
  assign flag_hi[13]  = 1'b0;
  assign flag_hi[12]  = single_buf & eoq_reg;
  assign flag_hi[11]  = 1'b0;
  assign flag_hi[10]  = stat_reg[0];
  assign flag_hi[9]   = stat_reg[1] & pass_en[0];
  assign flag_hi[8]   = stat_reg[2] & pass_en[0];
  assign flag_hi[7]   = stat_reg[3] & pass_en[0];
  assign flag_hi[6]   = stat_reg[4] & pass_en[1];
  assign flag_hi[5]   = stat_reg[5] & pass_en[3];
  assign flag_hi[4]   = stat_reg[6] | trunc_reg;
  assign flag_hi[3]   = stat_reg[7] & pass_en[0];
  assign flag_hi[2]   = stat_reg[8] & pass_en[0];
  assign flag_hi[1]   = stat_reg[9] & pass_en[0];
  assign flag_hi[0]   = stat_reg[10] & pass_en[2];

  assign sop_word = {flag_hi, {(16-LEN_W){1'b0}}, frame_cnt_reg};
  assign eop_word = {1'b0, 1'b1, 1'b0, eoq_reg, 28'h000_0000};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg              <= S_IDLE;
      cur_reg                <= `RDW_ZERO32;
      next_reg               <= `RDW_ZERO32;
      buf_reg                <= `RDW_ZERO32;
      buf_len_reg            <= {LEN_W{1'b0}};
      sop_desc_reg           <= `RDW_ZERO32;
      is_sop_reg             <= 1'b0;
      in_frame_reg           <= 1'b0;
      frame_end_reg          <= 1'b0;
      buf_cnt_reg            <= {LEN_W{1'b0}};
      frame_cnt_reg          <= {LEN_W{1'b0}};
      write_offset_value_reg <= `RDW_ZERO16;
      last_reg               <= 1'b0;
      trunc_reg              <= 1'b0;
      eoq_reg                <= 1'b0;
      stat_reg               <= 11'h000;
      td_pend_reg            <= 1'b0;
      td_done_reg            <= 1'b0;
      halted_reg             <= 1'b0;
      frames_reg             <= `RDW_ZERO32;
      mem_req                <= 1'b0;
      mem_write              <= 1'b0;
      mem_byte               <= 1'b0;
      mem_addr               <= `RDW_ZERO32;
      mem_wdata              <= `RDW_ZERO32;
      rx_ready               <= 1'b0;
    end else begin
      // a teardown request arriving with its own completion is kept
      if (td_pulse)
        td_pend_reg <= 1'b1;
      if (start_pulse)
        td_done_reg <= 1'b0;
      case (state_reg)
        S_IDLE, S_HALT: begin
          // a restart after a halt reloads from the head pointer
          if (start_pulse) begin
            cur_reg     <= head_ptr;
            halted_reg  <= 1'b0;
            td_pend_reg <= td_pulse;
            state_reg   <= S_RDNEXT;
          end else if (td_pend_reg) begin
            // no free descriptor to mark, report completion only
            td_pend_reg <= td_pulse;
            td_done_reg <= 1'b1;
            halted_reg  <= 1'b0;
            state_reg   <= S_IDLE;
          end
        end
        S_RDNEXT: begin
          // the link is sampled once; later appends to a null link are missed
          if (mem_ack) begin
            mem_req   <= 1'b0;
            next_reg  <= {mem_rdata[31:2], 2'b00};
            state_reg <= S_RDBUF;
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_write <= 1'b0;
            mem_byte  <= 1'b0;
            mem_addr  <= cur_reg + `RDW_DESC_NEXT;
          end
        end
        S_RDBUF: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            buf_reg   <= mem_rdata;
            state_reg <= S_RDLEN;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= cur_reg + `RDW_DESC_BUF;
          end
        end
        S_RDLEN: begin
          if (mem_ack) begin
            mem_req     <= 1'b0;
            buf_len_reg <= mem_rdata[LEN_W-1:0];
            buf_cnt_reg <= {LEN_W{1'b0}};
            state_reg   <= S_WAIT;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= cur_reg + `RDW_DESC_LEN;
          end
        end
        S_WAIT: begin
          // teardown is honoured only between frames
          if (in_frame_reg) begin
            rx_ready  <= 1'b1;
            state_reg <= S_DATA;
          end else if (td_pend_reg) begin
            state_reg <= S_TD;
          end else if (rx_valid) begin
            in_frame_reg  <= 1'b1;
            is_sop_reg    <= 1'b1;
            sop_desc_reg  <= cur_reg;
            frame_cnt_reg <= {LEN_W{1'b0}};
            trunc_reg     <= 1'b0;
            eoq_reg       <= 1'b0;
            write_offset_value_reg <= rx_write_offset_setting;
            rx_ready      <= 1'b1;
            state_reg     <= S_DATA;
          end
        end
        S_DATA: begin
          if (rx_take) begin
            rx_ready  <= 1'b0;
            last_reg  <= rx_last;
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_byte  <= 1'b1;
            mem_addr  <= byte_addr;
            mem_wdata <= {24'h000000, rx_data};
            if (rx_last)
              stat_reg <= {rx_address_miss, rx_checksum_fault, rx_alignment_fault,
                           rx_symbol_fault, rx_overrun, rx_control_frame, rx_undersize,
                           rx_fragment, rx_oversize, rx_jabber, rx_crc_kept};
            state_reg <= S_BYTE;
          end
        end
        S_BYTE: begin
          if (mem_ack) begin
            mem_req       <= 1'b0;
            buf_cnt_reg   <= buf_cnt_reg + 1'b1;
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
            if (last_reg) begin
              frame_end_reg <= 1'b1;
              state_reg     <= S_WBLEN;
            end else if (buf_cnt_reg + 1'b1 == cap) begin
              if (next_reg == `RDW_ZERO32) begin
                // no buffer left mid-frame: the tail is discarded
                trunc_reg <= 1'b1;
                rx_ready  <= 1'b1;
                state_reg <= S_DROP;
              end else begin
                frame_end_reg <= 1'b0;
                state_reg     <= S_WBLEN;
              end
            end else begin
              rx_ready  <= 1'b1;
              state_reg <= S_DATA;
            end
          end
        end
        S_DROP: begin
          if (rx_take && rx_last) begin
            rx_ready      <= 1'b0;
            stat_reg      <= {rx_address_miss, rx_checksum_fault, rx_alignment_fault,
                              rx_symbol_fault, rx_overrun, rx_control_frame, rx_undersize,
                              rx_fragment, rx_oversize, rx_jabber, rx_crc_kept};
            frame_end_reg <= 1'b1;
            state_reg     <= S_WBLEN;
          end
        end
        S_WBLEN: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (frame_end_reg) begin
              eoq_reg   <= (next_reg == `RDW_ZERO32);
              state_reg <= single_buf ? S_WBSOP : S_WBEOP;
            end else begin
              is_sop_reg <= 1'b0;
              cur_reg    <= next_reg;
              state_reg  <= S_RDNEXT;
            end
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_byte  <= 1'b0;
            mem_addr  <= cur_reg + `RDW_DESC_LEN;
            mem_wdata <= {is_sop_reg ? write_offset_value_reg : `RDW_ZERO16,
                          {(16-LEN_W){1'b0}}, buf_cnt_reg};
          end
        end
        S_WBEOP: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            state_reg <= S_WBSOP;
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_addr  <= cur_reg + `RDW_DESC_FLAGS;
            mem_wdata <= eop_word;
          end
        end
        S_WBSOP: begin
          // written last so the released device_held_flag flag covers every buffer
          if (mem_ack) begin
            mem_req      <= 1'b0;
            in_frame_reg <= 1'b0;
            is_sop_reg   <= 1'b0;
            frames_reg   <= frames_reg + 32'h0000_0001;
            if (eoq_reg) begin
              halted_reg <= 1'b1;
              state_reg  <= S_HALT;
            end else begin
              cur_reg   <= next_reg;
              state_reg <= S_RDNEXT;
            end
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_addr  <= sop_desc_reg + `RDW_DESC_FLAGS;
            mem_wdata <= sop_word;
          end
        end
        S_TD: begin
          if (mem_ack) begin
            mem_req     <= 1'b0;
            td_pend_reg <= td_pulse;
            td_done_reg <= 1'b1;
            state_reg   <= S_IDLE;
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_byte  <= 1'b0;
            mem_addr  <= cur_reg + `RDW_DESC_FLAGS;
            mem_wdata <= 32'h0000_0000 | (32'h0000_0001 << `RDW_F_TDDONE);
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // rdw_top

/* File: rdw_top_monitor.sv */
// assertion checker for the descriptor writeback engine ports
`timescale 1ns/10ps
module rdw_top_monitor (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // register bus answer
  input wire        hreadyout,
  input wire        hresp,
  // host memory master
  input wire        mem_req,
  input wire        mem_write,
  input wire        mem_byte,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  // byte stream
  input wire        rx_valid,
  input wire [7:0]  rx_data,
  input wire        rx_ready
);
  reg  [7:0] byte_reg;
  wire       word_wr = mem_req && mem_write && !mem_byte;
  wire       flag_wr = word_wr && (mem_addr[3:2] == 2'h3);
  always @(posedge hclk) if (rx_valid && rx_ready) byte_reg <= rx_data;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata)) else $error("memory request changed before ack");
  req_drop_a: assert property (mem_ack |=> !mem_req) else $error("request kept after ack");
  word_align_a: assert property (mem_req && !mem_byte |-> mem_addr[1:0] == 2'h0)
    else $error("word access not aligned");
  // bench descriptors are 16-byte aligned, so link and buffer words sit at +0 and +4
  desc_ro_a: assert property (word_wr |-> mem_addr[3] == 1'b1)
    else $error("link or buffer word written");
  device_held_flag_clr_a: assert property (flag_wr && mem_wdata[31] |-> !mem_wdata[29])
    else $error("start descriptor still held");
  eoq_eop_a: assert property (flag_wr && mem_wdata[28] |-> mem_wdata[30])
    else $error("queue end without frame end");
  byte_store_a: assert property (rx_valid && rx_ready |-> ##[1:60]
    (mem_req && mem_byte && mem_write && mem_wdata[7:0] == byte_reg))
    else $error("taken byte not stored");
  rx_pace_a: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("byte taken back to back");
  sop_eop_c: cover property (flag_wr && mem_wdata[31:30] == 2'h3);
  eoq_c: cover property (flag_wr && mem_wdata[28]);
  tdown_c: cover property (flag_wr && mem_wdata[27]);
endmodule // rdw_top_monitor

bind rdw_top rdw_top_monitor u_rdw_top_monitor (.hclk, .hresetn, .hreadyout, .hresp,
  .mem_req, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_ack, .rx_valid, .rx_data,
  .rx_ready);

/* File: rdw_top_test.sv */
// self-checking testbench of the descriptor writeback engine
`timescale 1ns/10ps
module rdw_top_test;
  reg         hclk, hresetn, hwrite, rx_valid, rx_last;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, rd;
  reg  [7:0]  rx_data;
  reg  [10:0] st;
  reg  [3:0]  lat;
  wire [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
  wire        hready, hresp, mem_req, mem_write, mem_byte, mem_ack, rx_ready;
  integer     failures, checks, i;

  rdw_top u_rdw_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .mem_req,
    .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .rx_valid,
    .rx_data, .rx_last, .rx_ready, .rx_crc_kept(st[10]), .rx_jabber(st[9]),
    .rx_oversize(st[8]), .rx_fragment(st[7]), .rx_undersize(st[6]),
    .rx_control_frame(st[5]), .rx_overrun(st[4]), .rx_symbol_fault(st[3]),
    .rx_alignment_fault(st[2]), .rx_checksum_fault(st[1]), .rx_address_miss(st[0]));
  rdw_mem_model u_rdw_mem_model (.hclk, .hresetn, .mem_req, .mem_write, .mem_byte,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .lat);

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task summarize;
    begin
      if (failures == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // single word transfer; waits on hready, never on a fixed count
  task ahb(input w, input [31:0] a, input [31:0] d);
    begin
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
    end
  endtask

  // empty descriptor as software queues it: held flag only, buffer length ln, offset and frame length cleared
  task desc(input [31:0] a, input [31:0] nx, input [31:0] bf, input [15:0] ln);
    begin
      u_rdw_mem_model.m[a[9:2]] = nx;
      u_rdw_mem_model.m[a[9:2] + 8'h1] = bf;
      u_rdw_mem_model.m[a[9:2] + 8'h2] = {16'h0, ln};
      u_rdw_mem_model.m[a[9:2] + 8'h3] = 32'h2000_0000;
    end
  endtask

  function [31:0] mw(input [31:0] a);
    mw = u_rdw_mem_model.m[a[9:2]];
  endfunction

  task wait_bit(input [31:0] a, input integer b, input v);
    integer n;
    begin
      for (n = 0; n < 2000 && mw(a) >> b & 1 ^ v; n = n + 1) @(posedge hclk);
    end
  endtask

  task send(input integer n, input [7:0] b0);
    begin
      for (i = 0; i < n; i = i + 1) begin
        rx_valid <= 1'b1;
        rx_data  <= b0 + i[7:0];
        rx_last  <= (i == n - 1);
        do @(posedge hclk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
    end
  endtask

  task s_single;
    begin
      desc(32'h100, 32'h110, 32'h200, 16'h4);
      desc(32'h110, 32'h120, 32'h240, 16'h3);
      desc(32'h120, 32'h0, 32'h280, 16'h4);
      ahb(1'b1, 32'h8, 32'h1);
      ahb(1'b1, 32'h0, 32'hF0);
      ahb(1'b1, 32'h4, 32'h100);
      st <= 11'h7FF;
      send(1, 8'hA5);
      wait_bit(32'h10C, 29, 1'b0);
      rd = mw(32'h200);
      chk("byte", rd[15:8], 32'hA5);
      chk("len", mw(32'h108), 32'h0001_0001);
      chk("flags", mw(32'h10C), 32'hC7FF_0001);
      chk("flags", mw(32'h10C), 32'hC7FF_0001);
      chk("flags", mw(32'h10C), 32'hC7FF_0001);
      chk("link", mw(32'h100), 32'h110);
      chk("bufp", mw(32'h104), 32'h200);
    end
  endtask

  task s_multi;
    begin
      // all pass enables off: only crc kept and overrun may show
      ahb(1'b1, 32'h0, 32'h0);
      lat <= 4'h3;
      st  <= 11'h7FF;
      send(3, 8'h10);
      wait_bit(32'h11C, 29, 1'b0);
      chk("len1", mw(32'h118), 32'h0001_0002);
      chk("flg1", mw(32'h11C), 32'h8410_0003);
      chk("flg1", mw(32'h11C), 32'h8410_0003);
      chk("len2", mw(32'h128), 32'h0000_0001);
      rd = mw(32'h12C);
      chk("flg2", rd & 32'hD000_0000, 32'h5000_0000);
      rd = mw(32'h280);
      chk("byte2", rd[7:0], 32'h12);
      rd = mw(32'h240);
      chk("byte1", rd[23:8], 32'h1110);
      ahb(1'b0, 32'hC, 32'h0);
      chk("halt", rd[1], 32'h1);
      ahb(1'b0, 32'h10, 32'h0);
      chk("cur", rd, 32'h120);
      ahb(1'b0, 32'h14, 32'h0);
      chk("frames", rd, 32'h2);
    end
  endtask

  task s_tdown;
    begin
      desc(32'h130, 32'h0, 32'h2C0, 16'h4);
      ahb(1'b1, 32'h4, 32'h130);
      // teardown acts between frames, so let the fetch of the new head finish
      repeat (40) @(posedge hclk);
      ahb(1'b1, 32'h0, 32'h1);
      wait_bit(32'h13C, 27, 1'b1);
      rd = mw(32'h13C);
      chk("tdflg", rd & 32'hC800_0000, 32'h0800_0000);
      ahb(1'b0, 32'hC, 32'h0);
      chk("tdst", rd[2], 32'h1);
      rx_valid <= 1'b1;
      repeat (50) begin
        @(posedge hclk);
        chk("stop", rx_ready, 32'h0);
      end
      rx_valid <= 1'b0;
      ahb(1'b0, 32'h40, 32'h0);
      chk("unmap", rd, 32'h0);
    end
  endtask

  initial begin
    hresetn  = 1'b0;
    hwrite   = 1'b0;
    htrans   = 2'h0;
    haddr    = 32'h0;
    hwdata   = 32'h0;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = 8'h0;
    st       = 11'h0;
    lat      = 4'h0;
    failures = 0;
    checks   = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_single;
    s_multi;
    s_tdown;
    summarize;
  end

  initial begin
    #100000;
    failures = failures + 1;
    summarize;
  end
endmodule // rdw_top_test
